/* File: logic/eli_consts.svh */
// Constants for the enclave and secure-launch interaction block
`ifndef ELI_CONSTS_SVH
`define ELI_CONSTS_SVH
`define ELI_STATUS_ADDR 12'h500
`define ELI_LOCK_BIT 0
`define ELI_THRESH_LSB 16
`define ELI_THRESH_MSB 23
`define ELI_STATUS_RESET 64'h0000_0000_0000_0000
`endif

/* File: logic/eli_pkg.sv */
// Types shared by the enclave and secure-launch interaction block
package eli_pkg;
  typedef enum logic [2:0] {
    ELI_RUN = 3'b000,
    ELI_EXIT_ASYNC = 3'b001,
    ELI_WAIT_SIPI = 3'b010,
    ELI_PAUSE = 3'b011,
    ELI_RESUME = 3'b100
  } eli_resp_t;
  typedef logic [7:0] eli_ver_t;
endpackage : eli_pkg

/* File: logic/eli_lock_if.sv */
// Interface carrying the lock state between the top and the launch checker
`timescale 1ns/10ps
interface eli_lock_if;
  logic lock;
  logic [7:0] thresh;
  modport owner (output lock, output thresh);
  modport user (input lock, input thresh);
endinterface : eli_lock_if

/* File: logic/eli_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module eli_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);
  logic s1_q;
  // First stage feeds only the second
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= 1'b0;
      q_out <= 1'b0;
    end else begin
      s1_q <= d_in;
      q_out <= s1_q;
    end
  end
endmodule : eli_sync

/* File: logic/eli_launch_check.sv */
// Version check applied when a code module asks to launch
`timescale 1ns/10ps
module eli_launch_check
  import eli_pkg::*;
(
  eli_lock_if.user lk,
  input wire logic [7:0] mod_version_in,
  output logic block_out
);
  // Shut down only when locked and version below threshold
  always_comb begin
    block_out = lk.lock && (mod_version_in < lk.thresh);
  end
endmodule : eli_launch_check

/* File: logic/eli_top.sv */
// Enclave interaction with the measured secure-launch instruction
`timescale 1ns/10ps
`include "eli_consts.svh"
module eli_top
  import eli_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic in_enclave_in,
  input wire logic launch_instr_in,
  input wire logic launch_enter_evt_in,
  input wire logic launch_exit_evt_in,
  input wire logic launch_exit_done_in,
  input wire logic sipi_pin_in,
  input wire logic encl_instr_done_in,
  input wire logic encl_instr_fault_in,
  input wire logic encl_instr_err_in,
  input wire logic [7:0] fw_thresh_in,
  input wire logic safer_mode_cap_in,
  input wire logic mod_launch_req_in,
  input wire logic mod_signed_ok_in,
  input wire logic [7:0] mod_version_in,
  input wire logic msr_rd_in,
  input wire logic [11:0] msr_addr_in,
  output logic [63:0] msr_rdata_out,
  output logic msr_rd_ack_out,
  output logic invalid_opcode_fault_out,
  output logic launch_exec_out,
  output logic async_enclave_exit_out,
  output logic wait_sipi_out,
  output logic paused_out,
  output logic launch_shutdown_out,
  output logic launch_go_out,
  output logic enclave_keep_out
);
  // ----------------------------------------
  // Lock state
  // ----------------------------------------
  eli_lock_if lk_if ();
  logic lock_q, lock_d;
  eli_ver_t thresh_q, thresh_d;
  logic sipi_s;
  // Lock on first clean enclave instruction, then hold until reset
  always_comb begin
    lock_d = lock_q;
    thresh_d = thresh_q;
    if (!lock_q && encl_instr_done_in && !encl_instr_fault_in && !encl_instr_err_in) begin
      lock_d = 1'b1;
      thresh_d = fw_thresh_in;
    end
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_q <= 1'b0;
      thresh_q <= 8'h00;
    end else begin
      lock_q <= lock_d;
      thresh_q <= thresh_d;
    end
  end
  assign lk_if.lock = lock_q;
  assign lk_if.thresh = lock_q ? thresh_q : fw_thresh_in;

  // Startup interrupt arrives from a pin
  eli_sync u_sipi (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .d_in(sipi_pin_in),
    .q_out(sipi_s)
  );

  // ----------------------------------------
  // Launch version check
  // ----------------------------------------
  logic blk;
  eli_launch_check u_chk (
    .lk(lk_if.user),
    .mod_version_in(mod_version_in),
    .block_out(blk)
  );
  logic shut_q, shut_d, go_q, go_d;
  // Launch outcome for a correctly signed module
  always_comb begin
    shut_d = 1'b0;
    go_d = 1'b0;
    if (mod_launch_req_in && mod_signed_ok_in) begin
      shut_d = blk;
      go_d = !blk;
    end
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shut_q <= 1'b0;
      go_q <= 1'b0;
    end else begin
      shut_q <= shut_d;
      go_q <= go_d;
    end
  end
  assign launch_shutdown_out = shut_q;
  assign launch_go_out = go_q;

  // ----------------------------------------
  // Instruction gating
  // ----------------------------------------
  logic ud_q, ud_d, ex_q, ex_d;
  // Fault instead of execute while inside an enclave
  always_comb begin
    ud_d = launch_instr_in && in_enclave_in;
    ex_d = launch_instr_in && !in_enclave_in;
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ud_q <= 1'b0;
      ex_q <= 1'b0;
    end else begin
      ud_q <= ud_d;
      ex_q <= ex_d;
    end
  end
  assign invalid_opcode_fault_out = ud_q;
  assign launch_exec_out = ex_q;

  // ----------------------------------------
  // Responder sequence
  // ----------------------------------------
  eli_resp_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    case (st_q)
      ELI_RUN: begin
        if (launch_enter_evt_in && in_enclave_in) begin
          st_d = ELI_EXIT_ASYNC;
        end else if (launch_exit_evt_in && in_enclave_in) begin
          st_d = ELI_PAUSE;
        end
      end
      ELI_EXIT_ASYNC: st_d = ELI_WAIT_SIPI;
      ELI_WAIT_SIPI: begin
        if (sipi_s) begin
          st_d = ELI_RUN;
        end
      end
      ELI_PAUSE: begin
        if (launch_exit_done_in) begin
          st_d = ELI_RESUME;
        end
      end
      ELI_RESUME: st_d = ELI_RUN;
      default: st_d = ELI_RUN;
    endcase
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= ELI_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Responder outputs
  // ----------------------------------------
  logic async_q, async_d, wait_q, wait_d, pause_q, pause_d, keep_q, keep_d;
  // Decode the next state so the async, wait and pause outputs each leave a flop
  always_comb begin
    async_d = (st_d == ELI_EXIT_ASYNC);
    wait_d = (st_d == ELI_WAIT_SIPI);
    pause_d = (st_d == ELI_PAUSE);
    keep_d = 1'b1;
  end
  // Launch logic never writes enclave configuration, so keep stays high
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      async_q <= 1'b0;
      wait_q <= 1'b0;
      pause_q <= 1'b0;
      keep_q <= 1'b1;
    end else begin
      async_q <= async_d;
      wait_q <= wait_d;
      pause_q <= pause_d;
      keep_q <= keep_d;
    end
  end
  assign async_enclave_exit_out = async_q;
  assign wait_sipi_out = wait_q;
  assign paused_out = pause_q;
  assign enclave_keep_out = keep_q;

  // ----------------------------------------
  // Status register read port
  // ----------------------------------------
  logic [63:0] rd_q, rd_d;
  logic ack_q, ack_d;
  always_comb begin
    rd_d = `ELI_STATUS_RESET;
    ack_d = msr_rd_in;
    if (msr_rd_in && msr_addr_in == `ELI_STATUS_ADDR) begin
      rd_d[`ELI_LOCK_BIT] = lock_q;
      if (safer_mode_cap_in) begin
        rd_d[`ELI_THRESH_MSB:`ELI_THRESH_LSB] = lk_if.thresh;
      end
    end
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_q <= `ELI_STATUS_RESET;
      ack_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      ack_q <= ack_d;
    end
  end
  assign msr_rdata_out = rd_q;
  assign msr_rd_ack_out = ack_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_fault_in_enclave: assert property (@(posedge core_clk_in) disable iff (rst_in)
    launch_instr_in && in_enclave_in |=> invalid_opcode_fault_out && !launch_exec_out)
    else $error("launch leaf not faulted in enclave");
  sequence s_enter;
    st_q == ELI_RUN && launch_enter_evt_in && in_enclave_in;
  endsequence
  a_enter_exit_wait: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_enter |=> async_enclave_exit_out ##1 wait_sipi_out)
    else $error("enter did not exit then wait");
  a_exit_pause: assert property (@(posedge core_clk_in) disable iff (rst_in)
    paused_out && launch_exit_done_in |=> !paused_out ##1 !paused_out)
    else $error("pause did not end after exit");
  a_keep_cfg: assert property (@(posedge core_clk_in) disable iff (rst_in)
    enclave_keep_out)
    else $error("enclave config disturbed");
  a_lock_set: assert property (@(posedge core_clk_in) disable iff (rst_in)
    encl_instr_done_in && !encl_instr_fault_in && !encl_instr_err_in |=> lock_q)
    else $error("lock not set");
  a_lock_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    lock_q |=> lock_q && $stable(thresh_q))
    else $error("lock state changed");
  a_shut_low: assert property (@(posedge core_clk_in) disable iff (rst_in)
    mod_launch_req_in && mod_signed_ok_in && lock_q && mod_version_in < thresh_q |=> launch_shutdown_out)
    else $error("no shutdown for old module");
  a_go_unlocked: assert property (@(posedge core_clk_in) disable iff (rst_in)
    mod_launch_req_in && mod_signed_ok_in && !lock_q |=> launch_go_out && !launch_shutdown_out)
    else $error("unlocked launch refused");
  a_rsvd_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
    msr_rd_ack_out |-> msr_rdata_out[15:1] == 15'h0000 && msr_rdata_out[63:24] == 40'h00_0000_0000)
    else $error("reserved bits set");
  a_field_gate: assert property (@(posedge core_clk_in) disable iff (rst_in)
    msr_rd_in && !safer_mode_cap_in |=> msr_rdata_out[23:16] == 8'h00)
    else $error("threshold shown without capability");
  // Leaf outside an enclave executes
  a_exec_outside: assert property (@(posedge core_clk_in) disable iff (rst_in)
    launch_instr_in && !in_enclave_in |=> launch_exec_out && !invalid_opcode_fault_out)
    else $error("launch leaf not executed outside enclave");
  sequence s_exit_evt;
    st_q == ELI_RUN && launch_exit_evt_in && in_enclave_in && !launch_enter_evt_in;
  endsequence
  // Exit event inside an enclave pauses the responder
  a_exit_entry: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_exit_evt |=> paused_out)
    else $error("exit event did not pause");
  // Startup interrupt ends the wait
  a_sipi_release: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wait_sipi_out && sipi_s |=> !wait_sipi_out)
    else $error("wait not left on startup interrupt");
  // Every read is acknowledged
  a_rd_ack: assert property (@(posedge core_clk_in) disable iff (rst_in)
    msr_rd_in |=> msr_rd_ack_out)
    else $error("read not acknowledged");
  // Lock bit reports the lock state
  a_lock_bit_rd: assert property (@(posedge core_clk_in) disable iff (rst_in)
    msr_rd_in && msr_addr_in == `ELI_STATUS_ADDR |=> msr_rdata_out[`ELI_LOCK_BIT] == $past(lock_q))
    else $error("lock bit misreported");
  // Other addresses read as zero
  a_unmapped_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
    msr_rd_in && msr_addr_in != `ELI_STATUS_ADDR |=> msr_rdata_out == 64'h0000_0000_0000_0000)
    else $error("unmapped read not zero");
  // Unsigned module gives no outcome
  a_unsigned_idle: assert property (@(posedge core_clk_in) disable iff (rst_in)
    mod_launch_req_in && !mod_signed_ok_in |=> !launch_go_out && !launch_shutdown_out)
    else $error("unsigned module got an outcome");
  // Locking captures the firmware threshold
  a_thresh_capture: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !lock_q && encl_instr_done_in && !encl_instr_fault_in && !encl_instr_err_in
      |=> thresh_q == $past(fw_thresh_in))
    else $error("threshold not captured");
endmodule : eli_top

/* File: tb/eli_partner.sv */
// Software model that reads launch status before launching a code module
`timescale 1ns/10ps
module eli_partner (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [11:0] addr_in,
  input wire logic launch_in,
  input wire logic frc_in,
  input wire logic [7:0] ver_in,
  input wire logic ack_in,
  input wire logic [63:0] rdata_in,
  output logic msr_rd_out,
  output logic [11:0] msr_addr_out,
  output logic mod_req_out,
  output logic [7:0] mod_ver_out,
  output logic stale_out,
  output logic done_out
);
  logic [63:0] st;
  initial begin
    {msr_rd_out, mod_req_out, stale_out, done_out} = 4'h0;
    msr_addr_out = 12'hFFF;
    mod_ver_out = 8'hFF;
  end
  // Read status, then launch only an acceptable module unless told to force
  always @(posedge clk_in) begin
    if (go_in) begin
      msr_rd_out <= 1'b1;
      msr_addr_out <= addr_in;
      @(posedge clk_in);
      msr_rd_out <= 1'b0;
      msr_addr_out <= ~addr_in;
      for (int i = 0; i < 8 && !ack_in; i++) @(posedge clk_in);
      st = rdata_in;
      if (launch_in && (frc_in || !st[0] || ver_in >= st[23:16])) begin
        mod_req_out <= 1'b1;
        mod_ver_out <= ver_in;
        @(posedge clk_in);
        mod_req_out <= 1'b0;
        mod_ver_out <= ~ver_in;
      end
      // Flag a module that should be replaced, locked or not
      stale_out <= ver_in < st[23:16];
      done_out <= 1'b1;
      @(posedge clk_in);
      done_out <= 1'b0;
    end
  end
endmodule : eli_partner

/* File: tb/eli_top_test.sv */
// Self-checking bench for the enclave and secure-launch interaction block
`timescale 1ns/10ps
`include "eli_consts.svh"
module eli_top_test;
  import eli_pkg::*;
  logic clk, rst, encl, li, ent, ext, exd, sipi, dn, flt, er, cap, go, lau, frc, pd, lock_m, sok, stl;
  logic ack, f_o, x_o, a_o, w_o, p_o, s_o, g_o, k_o, rd, req;
  logic [7:0] fw, ver, mver, thr_m;
  logic [11:0] addr, maddr;
  logic [63:0] rdata;
  logic [69:0] exp_q[$];
  logic [31:0] rs;
  int fails, n_tests, cyc;
  eli_top dut (.core_clk_in(clk), .rst_in(rst), .in_enclave_in(encl), .launch_instr_in(li),
    .launch_enter_evt_in(ent), .launch_exit_evt_in(ext), .launch_exit_done_in(exd), .sipi_pin_in(sipi),
    .encl_instr_done_in(dn), .encl_instr_fault_in(flt), .encl_instr_err_in(er), .fw_thresh_in(fw),
    .safer_mode_cap_in(cap), .mod_launch_req_in(req), .mod_signed_ok_in(sok), .mod_version_in(mver),
    .msr_rd_in(rd), .msr_addr_in(maddr), .msr_rdata_out(rdata), .msr_rd_ack_out(ack),
    .invalid_opcode_fault_out(f_o), .launch_exec_out(x_o), .async_enclave_exit_out(a_o),
    .wait_sipi_out(w_o), .paused_out(p_o), .launch_shutdown_out(s_o), .launch_go_out(g_o),
    .enclave_keep_out(k_o));
  eli_partner sw_m (.clk_in(clk), .go_in(go), .addr_in(addr), .launch_in(lau), .frc_in(frc), .ver_in(ver),
    .ack_in(ack), .rdata_in(rdata), .msr_rd_out(rd), .msr_addr_out(maddr), .mod_req_out(req),
    .mod_ver_out(mver), .stale_out(stl), .done_out(pd));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [69:0] got, input logic [69:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("counts: n_tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // Software reads status and maybe launches; expectations noted first
  task automatic sw(input logic [11:0] a, input logic l, input logic f, input logic [7:0] v);
    logic [7:0] fld;
    logic sh;
    fld = !cap ? 8'h00 : lock_m ? thr_m : fw;
    exp_q.push_back({6'h01, a == `ELI_STATUS_ADDR ? {40'h0, fld, 15'h0, lock_m} : 64'h0});
    sh = lock_m && v < thr_m;
    if (l && sok && (f || !lock_m || v >= fld)) exp_q.push_back({3'h0, sh, !sh, 65'h0});
    {addr, lau, frc, ver, go} <= {a, l, f, v, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    for (int k = 0; k < 20 && pd !== 1'b1; k++) @(posedge clk);
    chk({69'h0, stl}, {69'h0, a == `ELI_STATUS_ADDR && v < fld});
  endtask : sw
  // Pulse one event, then let an edge pass before the next one
  task automatic ev(input int k);
    {li, ent, ext, exd, dn} <= 5'h10 >> k;
    @(posedge clk);
    {li, ent, ext, exd, dn} <= 5'h00;
    @(posedge clk);
  endtask : ev
  task automatic lvl(input logic w, input logic p);
    @(negedge clk);
    chk({67'h0, k_o, w_o, p_o}, {67'h0, 1'b1, w, p});
    @(posedge clk);
  endtask : lvl
  // Every result pulse is matched against the oldest note
  always @(negedge clk) begin
    if (!rst && (ack || f_o || x_o || a_o || s_o || g_o)) begin
      chk({f_o, x_o, a_o, s_o, g_o, ack, rdata}, exp_q.size() ? exp_q.pop_front() : 70'h0);
    end
  end
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    {encl, li, ent, ext, exd, sipi, dn, flt, er, go, lau, frc, lock_m} = '0;
    sok = 1'b1;
    {rst, cap, rs, fails, n_tests, cyc, thr_m, addr, ver} = {2'b11, 32'd90958, 96'h0, 28'h0};
    fw = xs(rs) | 8'h02;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    lvl(1'b0, 1'b0);
    sw(`ELI_STATUS_ADDR, 0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      sw(rs[11:0] == 12'h500 ? 12'h501 : rs[11:0], 0, 0, 0);
    end
    cap <= 1'b0;
    @(posedge clk);
    sw(`ELI_STATUS_ADDR, 0, 0, 0);
    cap <= 1'b1;
    @(posedge clk);
    sw(`ELI_STATUS_ADDR, 1, 1, fw - 8'h01);
    $display("test 1 done");
    exp_q.push_back({2'b01, 68'h0});
    ev(0);
    encl <= 1'b1;
    exp_q.push_back({1'b1, 69'h0});
    ev(0);
    $display("test 2 done");
    for (int q = 0; q < 3; q++) begin
      {flt, er} <= 2'b10 >> q;
      ev(4);
      lock_m = (q == 2);
      thr_m = fw;
      sw(`ELI_STATUS_ADDR, 0, 0, 0);
    end
    rs = xs(rs);
    fw <= rs[7:0];
    @(posedge clk);
    sw(`ELI_STATUS_ADDR, 0, 0, 0);
    sw(`ELI_STATUS_ADDR, 1, 0, thr_m);
    sw(`ELI_STATUS_ADDR, 1, 1, thr_m - 8'h01);
    sw(`ELI_STATUS_ADDR, 1, 0, thr_m - 8'h01);
    sok <= 1'b0;
    @(posedge clk);
    sw(`ELI_STATUS_ADDR, 1, 1, thr_m - 8'h01);
    sok <= 1'b1;
    $display("test 3 done");
    exp_q.push_back({3'b001, 67'h0});
    ev(1);
    @(posedge clk);
    lvl(1'b1, 1'b0);
    sipi <= 1'b1;
    repeat (4) @(posedge clk);
    lvl(1'b0, 1'b0);
    {sipi, encl} <= 2'b00;
    ev(1);
    $display("test 4 done");
    encl <= 1'b1;
    ev(2);
    lvl(1'b0, 1'b1);
    repeat (3) @(posedge clk);
    lvl(1'b0, 1'b1);
    ev(3);
    @(posedge clk);
    lvl(1'b0, 1'b0);
    $display("test 5 done");
    // Reset again: lock must be cleared, so the field shows the live firmware threshold
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    lock_m = 1'b0;
    sw(`ELI_STATUS_ADDR, 0, 0, 0);
    chk(70'(exp_q.size()), 70'h0);
    $display("test 6 done");
    conclude();
  end
endmodule : eli_top_test
